// ---- evr_batch_counter.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Batching event counter with programmable threshold.
// ----------------------------------------------------------------------------
module evr_batch_counter (
  // Clock and reset.
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Events and control.
  input  wire logic       accel_batch_in,
  input  wire logic       gyro_batch_in,
  input  wire logic       source_sel_in,
  input  wire logic [9:0] threshold_in,
  input  wire logic       clear_in,
  // Threshold hit.
  output logic            reached_out
);

  typedef struct packed {
    logic [9:0] count;
    logic       reached;
  } evr_cnt_state_t;

  evr_cnt_state_t state_reg;
  evr_cnt_state_t state_next;

  // Count the selected source; a zero threshold never fires, since the counter
  // would otherwise claim a hit on every event.
  always_comb begin
    logic ev;
    ev = source_sel_in ? gyro_batch_in : accel_batch_in;
    state_next = state_reg;
    state_next.reached = 1'b0;
    if (clear_in) begin
      state_next.count = 10'h000;
    end else if (ev) begin
      if ((threshold_in != 10'h000) && (state_reg.count + 10'h001 >= threshold_in)) begin
        state_next.count = 10'h000;
        state_next.reached = 1'b1;
      end else begin
        state_next.count = state_reg.count + 10'h001;
      end
    end
  end

  // State register.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign reached_out = state_reg.reached;

endmodule // evr_batch_counter

// ---- evr_event_router.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
module evr_event_router #(
  parameter int         PULSE_CYCLES = evr_pkg::PULSE_CYCLES,
  parameter logic [7:0] IDENTITY     = 8'ha5 // Arbitrary value.
) (
  // Clock and reset.
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // APB slave.
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Queue and system events.
  input  wire logic        queue_full_in,
  input  wire logic        queue_overrun_in,
  input  wire logic        queue_level_in,
  input  wire logic        boot_active_in,
  input  wire logic        sample_stamp_flag_in,
  input  wire logic        first_function_routing_in,
  input  wire logic        second_function_routing_in,
  // Sensor samples, batching events and data reads.
  input  wire logic        accel_sample_in,
  input  wire logic        gyro_sample_in,
  input  wire logic        temp_sample_in,
  input  wire logic        accel_read_in,
  input  wire logic        gyro_read_in,
  input  wire logic        temp_read_in,
  input  wire logic        accel_batch_in,
  input  wire logic        gyro_batch_in,
  // Accelerometer filter stages.
  input  wire logic [15:0] accel_stage1_in,
  input  wire logic [15:0] accel_stage2_in,
  // Interrupt pins.
  output logic             irq_pin_a_out,
  output logic             irq_pin_b_out,
  // Accelerometer configuration and data.
  output logic       [3:0] accel_rate_select_out,
  output logic             accel_power_down_out,
  output logic             accel_rate_forbidden_out,
  output logic       [4:0] accel_range_g_out,
  output logic      [15:0] accel_data_out
);

  // --------------------------------------------------------------------------
  // Decoding helpers.
  // --------------------------------------------------------------------------

  // Range codes are not in ascending order: 00/01/10/11 map to 2/16/4/8 g.
  function automatic logic [4:0] evr_range_g(input logic [1:0] code);
    unique case (code)
      2'b00: evr_range_g = 5'h02;
      2'b01: evr_range_g = 5'h10;
      2'b10: evr_range_g = 5'h04;
      2'b11: evr_range_g = 5'h08;
    endcase
  endfunction

  // Byte address to register index for a word-aligned access.
  function automatic logic [7:0] evr_index(input logic [11:0] addr);
    evr_index = addr[9:2];
  endfunction

  // --------------------------------------------------------------------------
  // State.
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  count_control;
    logic [7:0]  threshold_low;
    logic [7:0]  pin_a_enable;
    logic [7:0]  pin_b_enable;
    logic [7:0]  accel_control;
    logic [7:0]  pin_control;
    logic        count_event_flag;
    logic [31:0] rdata;
    logic        pin_a;
    logic        pin_b;
    logic [15:0] accel_data;
  } evr_state_t;

  evr_state_t state_reg;
  evr_state_t state_next;

  logic [7:0] idx;
  logic       mapped;
  logic       setup_phase;
  logic       access_done;
  logic       wr_done;
  logic       rd_done;
  logic       count_clear;
  logic       count_reached;
  logic       accel_ready;
  logic       gyro_ready;
  logic       temp_ready;
  logic [9:0] batch_count_threshold;
  logic       level_a;
  logic       level_b;
  logic [7:0] read_byte;

  // --------------------------------------------------------------------------
  // APB decode; one wait-free access phase after a setup cycle.
  // --------------------------------------------------------------------------
  assign idx         = evr_index(paddr_in);
  assign setup_phase = psel_in && !penable_in;
  assign access_done = psel_in && penable_in;
  assign wr_done     = access_done && pwrite_in && mapped;
  assign rd_done     = access_done && !pwrite_in && mapped;
  assign pready_out  = access_done;
  assign pslverr_out = access_done && !mapped;
  assign prdata_out  = state_reg.rdata;

  // Only the listed indices answer; anything else, or a misaligned address, errors.
  always_comb begin
    mapped = (paddr_in[1:0] == 2'b00) && (paddr_in[11:10] == 2'b00);
    unique case (idx)
      evr_pkg::IDX_COUNT_CONTROL,
      evr_pkg::IDX_THRESHOLD_LOW,
      evr_pkg::IDX_PIN_A_ENABLE,
      evr_pkg::IDX_PIN_B_ENABLE,
      evr_pkg::IDX_IDENTITY,
      evr_pkg::IDX_ACCEL_CONTROL,
      evr_pkg::IDX_PIN_CONTROL,
      evr_pkg::IDX_QUEUE_STATUS: mapped = mapped;
      default:                   mapped = 1'b0;
    endcase
  end

  // Read multiplexer; the clear bit is never stored, so it reads as zero.
  always_comb begin
    read_byte = evr_pkg::RST_BYTE;
    unique case (idx)
      evr_pkg::IDX_COUNT_CONTROL: read_byte = state_reg.count_control;
      evr_pkg::IDX_THRESHOLD_LOW: read_byte = state_reg.threshold_low;
      evr_pkg::IDX_PIN_A_ENABLE:  read_byte = state_reg.pin_a_enable;
      evr_pkg::IDX_PIN_B_ENABLE:  read_byte = state_reg.pin_b_enable;
      evr_pkg::IDX_IDENTITY:      read_byte = IDENTITY;
      evr_pkg::IDX_ACCEL_CONTROL: read_byte = state_reg.accel_control;
      evr_pkg::IDX_PIN_CONTROL:   read_byte = state_reg.pin_control;
      evr_pkg::IDX_QUEUE_STATUS:  read_byte[evr_pkg::QS_COUNT_HIT] = state_reg.count_event_flag;
      default:                    read_byte = evr_pkg::RST_BYTE;
    endcase
  end

  // --------------------------------------------------------------------------
  // Counter control and data-ready shaping.
  // --------------------------------------------------------------------------
  assign batch_count_threshold = {state_reg.count_control[1:0], state_reg.threshold_low};
  assign count_clear = wr_done && (idx == evr_pkg::IDX_COUNT_CONTROL)
                       && pwdata_in[evr_pkg::CC_CLEAR];

  evr_batch_counter u_counter (
    .clk_in         (clk_in),
    .rst_in         (rst_in),
    .accel_batch_in (accel_batch_in),
    .gyro_batch_in  (gyro_batch_in),
    .source_sel_in  (state_reg.count_control[evr_pkg::CC_SOURCE]),
    .threshold_in   (batch_count_threshold),
    .clear_in       (count_clear),
    .reached_out    (count_reached)
  );

  evr_ready_shaper #(.PULSE_CYCLES(PULSE_CYCLES)) u_accel_ready (
    .clk_in         (clk_in),
    .rst_in         (rst_in),
    .sample_in      (accel_sample_in),
    .read_in        (accel_read_in),
    .pulsed_mode_in (state_reg.count_control[evr_pkg::CC_PULSED]),
    .ready_out      (accel_ready)
  );

  evr_ready_shaper #(.PULSE_CYCLES(PULSE_CYCLES)) u_gyro_ready (
    .clk_in         (clk_in),
    .rst_in         (rst_in),
    .sample_in      (gyro_sample_in),
    .read_in        (gyro_read_in),
    .pulsed_mode_in (state_reg.count_control[evr_pkg::CC_PULSED]),
    .ready_out      (gyro_ready)
  );

  evr_ready_shaper #(.PULSE_CYCLES(PULSE_CYCLES)) u_temp_ready (
    .clk_in         (clk_in),
    .rst_in         (rst_in),
    .sample_in      (temp_sample_in),
    .read_in        (temp_read_in),
    .pulsed_mode_in (state_reg.count_control[evr_pkg::CC_PULSED]),
    .ready_out      (temp_ready)
  );

  // --------------------------------------------------------------------------
  // Pin source selection.
  // --------------------------------------------------------------------------

  // Pin A sources; the function routing input is already gated outside.
  always_comb begin
    level_a = first_function_routing_in;
    level_a |= state_reg.pin_a_enable[evr_pkg::EN_STAMP] && sample_stamp_flag_in;
    level_a |= state_reg.pin_a_enable[evr_pkg::EN_COUNT] && state_reg.count_event_flag;
    level_a |= state_reg.pin_a_enable[evr_pkg::EN_FULL] && queue_full_in;
    level_a |= state_reg.pin_a_enable[evr_pkg::EN_OVERRUN] && queue_overrun_in;
    level_a |= state_reg.pin_a_enable[evr_pkg::EN_LEVEL] && queue_level_in;
    level_a |= state_reg.pin_a_enable[evr_pkg::EN_BOOT_TEMP] && boot_active_in;
    level_a |= state_reg.pin_a_enable[evr_pkg::EN_GYRO] && gyro_ready;
    level_a |= state_reg.pin_a_enable[evr_pkg::EN_ACCEL] && accel_ready;
  end

  // Pin B sources; bit 7 is reserved and deliberately has no effect.
  always_comb begin
    level_b = second_function_routing_in;
    level_b |= state_reg.pin_b_enable[evr_pkg::EN_COUNT] && state_reg.count_event_flag;
    level_b |= state_reg.pin_b_enable[evr_pkg::EN_FULL] && queue_full_in;
    level_b |= state_reg.pin_b_enable[evr_pkg::EN_OVERRUN] && queue_overrun_in;
    level_b |= state_reg.pin_b_enable[evr_pkg::EN_LEVEL] && queue_level_in;
    level_b |= state_reg.pin_b_enable[evr_pkg::EN_BOOT_TEMP] && temp_ready;
    level_b |= state_reg.pin_b_enable[evr_pkg::EN_GYRO] && gyro_ready;
    level_b |= state_reg.pin_b_enable[evr_pkg::EN_ACCEL] && accel_ready;
  end

  // --------------------------------------------------------------------------
  // Next state.
  // --------------------------------------------------------------------------

  // Register writes, flag handling and pin outputs, all in one place so that
  // priorities between a write and a hardware update are visible.
  always_comb begin
    state_next = state_reg;
    if (setup_phase) begin
      state_next.rdata = {24'h000000, read_byte};
    end
    if (wr_done) begin
      unique case (idx)
        evr_pkg::IDX_COUNT_CONTROL: begin
          state_next.count_control = pwdata_in[7:0];
          state_next.count_control[evr_pkg::CC_CLEAR] = 1'b0;
        end
        evr_pkg::IDX_THRESHOLD_LOW: state_next.threshold_low = pwdata_in[7:0];
        evr_pkg::IDX_PIN_A_ENABLE:  state_next.pin_a_enable = pwdata_in[7:0];
        evr_pkg::IDX_PIN_B_ENABLE:  state_next.pin_b_enable = pwdata_in[7:0];
        evr_pkg::IDX_ACCEL_CONTROL: state_next.accel_control = pwdata_in[7:0];
        evr_pkg::IDX_PIN_CONTROL:   state_next.pin_control = pwdata_in[7:0];
        default:                    state_next.pin_control = state_reg.pin_control;
      endcase
    end
    // A new hit in the same cycle as the status read keeps the flag set.
    if (count_reached) begin
      state_next.count_event_flag = 1'b1;
    end else if (rd_done && (idx == evr_pkg::IDX_QUEUE_STATUS)) begin
      state_next.count_event_flag = 1'b0;
    end
    state_next.pin_a = level_a ^ state_reg.pin_control[evr_pkg::PC_POLARITY];
    state_next.pin_b = level_b ^ state_reg.pin_control[evr_pkg::PC_POLARITY];
    if (state_reg.accel_control[evr_pkg::AC_FILTER2]) begin
      state_next.accel_data = accel_stage2_in;
    end else begin
      state_next.accel_data = accel_stage1_in;
    end
  end

  // State register.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs.
  // --------------------------------------------------------------------------
  assign irq_pin_a_out            = state_reg.pin_a;
  assign irq_pin_b_out            = state_reg.pin_b;
  assign accel_rate_select_out    = state_reg.accel_control[7:4];
  assign accel_power_down_out     = state_reg.accel_control[7:4] == evr_pkg::RATE_POWER_DOWN;
  assign accel_rate_forbidden_out = state_reg.accel_control[7:4] > evr_pkg::RATE_HIGHEST;
  assign accel_range_g_out        = evr_range_g(state_reg.accel_control[3:2]);
  assign accel_data_out           = state_reg.accel_data;

endmodule // evr_event_router

// ---- evr_event_router_asserts.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Port checker for the event router.
// ----------------------------------------------------------------------------
module evr_event_router_asserts #(
  parameter logic [7:0] IDENTITY = 8'h00
) (
  // Clock, reset and APB.
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [31:0] prdata_out,
  // Routing and outputs.
  input  wire logic        first_function_routing_in,
  input  wire logic        second_function_routing_in,
  input  wire logic        irq_pin_a_out,
  input  wire logic        irq_pin_b_out,
  input  wire logic [3:0]  accel_rate_select_out,
  input  wire logic        accel_power_down_out,
  input  wire logic        accel_rate_forbidden_out,
  input  wire logic [4:0]  accel_range_g_out
);
  logic pol_reg;
  wire  rd_setup = psel_in && !penable_in && !pwrite_in;
  wire  wr_acc   = psel_in && penable_in && pwrite_in;
  // Shadow of the polarity bit, since no port shows it.
  always_ff @(posedge clk_in) begin
    if (rst_in) pol_reg <= 1'b0;
    else if (wr_acc && paddr_in == 12'h048) pol_reg <= pwdata_in[5];
  end
  function automatic logic [4:0] range_g(input logic [1:0] c);
    return (c == 2'h0) ? 5'h02 : (c == 2'h1) ? 5'h10 : (c == 2'h2) ? 5'h04 : 5'h08;
  endfunction
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  property p_identity; rd_setup && paddr_in == 12'h03c |=> prdata_out == {24'h0, IDENTITY}; endproperty
  a_identity: assert property (p_identity) else $error("identity read wrong");
  property p_clear_self; rd_setup && paddr_in == 12'h02c |=> prdata_out[6] == 1'b0; endproperty
  a_clear_self: assert property (p_clear_self) else $error("clear bit not self cleared");
  property p_power_down; accel_power_down_out == (accel_rate_select_out == 4'h0); endproperty
  a_power_down: assert property (p_power_down) else $error("power down decode wrong");
  property p_forbidden; accel_rate_forbidden_out == (accel_rate_select_out > 4'ha); endproperty
  a_forbidden: assert property (p_forbidden) else $error("forbidden decode wrong");
  property p_rate; wr_acc && paddr_in == 12'h040 |=> accel_rate_select_out == $past(pwdata_in[7:4]); endproperty
  a_rate: assert property (p_rate) else $error("rate field not taken");
  property p_range; wr_acc && paddr_in == 12'h040 |=> accel_range_g_out == range_g($past(pwdata_in[3:2])); endproperty
  a_range: assert property (p_range) else $error("range decode wrong");
  property p_pin_a; first_function_routing_in |=> irq_pin_a_out == !$past(pol_reg); endproperty
  a_pin_a: assert property (p_pin_a) else $error("pin a misses extra source");
  property p_pin_b; second_function_routing_in |=> irq_pin_b_out == !$past(pol_reg); endproperty
  a_pin_b: assert property (p_pin_b) else $error("pin b misses extra source");
  // Main scenarios reached.
  c_ident: cover property (rd_setup && paddr_in == 12'h03c);
  c_low_pin: cover property (first_function_routing_in && pol_reg);
  c_forbid: cover property (accel_rate_forbidden_out);
endmodule // evr_event_router_asserts

// ---- evr_event_router_tb.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Testbench for the event router.
// ----------------------------------------------------------------------------
module evr_event_router_tb;
  localparam int         PULSE = 8;
  localparam logic [7:0] IDENT = 8'h3c; // Arbitrary value.
  logic        clk_in, rst_in, psel, penable, pwrite, pready, pslverr, pin_a, pin_b, pdown, forbid, ffr, sfr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [7:0]  lv;
  logic [2:0]  smp, rdp;
  logic [1:0]  bat;
  logic [3:0]  rate;
  logic [4:0]  rg;
  logic [15:0] dat;
  logic [4:0]  rtab [4] = '{5'h02, 5'h10, 5'h04, 5'h08};
  int          error_cnt = 0;
  int          n_compared = 0;
  evr_event_router #(.PULSE_CYCLES(PULSE), .IDENTITY(IDENT)) u_evr_event_router (
    .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .queue_full_in(lv[5]), .queue_overrun_in(lv[4]), .queue_level_in(lv[3]), .boot_active_in(lv[2]),
    .sample_stamp_flag_in(lv[7]), .first_function_routing_in(ffr), .second_function_routing_in(sfr),
    .accel_sample_in(smp[0]), .gyro_sample_in(smp[1]), .temp_sample_in(smp[2]), .accel_read_in(rdp[0]),
    .gyro_read_in(rdp[1]), .temp_read_in(rdp[2]), .accel_batch_in(bat[0]), .gyro_batch_in(bat[1]),
    .accel_stage1_in(16'h1234), .accel_stage2_in(16'hbeef), .irq_pin_a_out(pin_a), .irq_pin_b_out(pin_b),
    .accel_rate_select_out(rate), .accel_power_down_out(pdown), .accel_rate_forbidden_out(forbid),
    .accel_range_g_out(rg), .accel_data_out(dat));
  evr_host_model u_evr_host_model (
    .clk_in(clk_in), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr),
    .pwdata_out(pwdata), .prdata_in(prdata), .pready_in(pready), .pslverr_in(pslverr));
  // Free-running 250 MHz clock.
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] x, input string n);
    u_evr_host_model.xfer(a, 1'b0, 8'h00, r, e);
    chk(n, r, x);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    u_evr_host_model.wr(a, d, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // Ready sources take a set or clear pulse; others are levels.
  task automatic src(input int p, input int b, input logic v);
    if (b < 2 || (b == 2 && p == 1)) begin
      if (v) smp[b] <= 1'b1;
      else rdp[b] <= 1'b1;
      @(posedge clk_in);
      smp <= 3'h0;
      rdp <= 3'h0;
    end else lv[b] <= v;
  endtask
  task automatic batch(input int k, input int n);
    repeat (n) begin
      bat[k] <= 1'b1;
      @(posedge clk_in);
      bat[k] <= 1'b0;
      @(posedge clk_in);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Tests take about 1340 cycles; this is over eighteen times that.
  initial begin
    #100000;
    error_cnt++;
    wrap_up();
  end
  // Main sequence.
  initial begin
    rst_in = 1'b1;
    {lv, smp, rdp, bat, ffr, sfr} = '0;
    tick(2);
    rst_in <= 1'b0;
    tick(1);
    chk("power_down", pdown, 1'b1);
    chk("range_rst", rg, 5'h02);
    rdc(12'h030, 32'h0, "thr_low_rst");
    wr(12'h03c, 8'hff);
    rdc(12'h03c, {24'h0, IDENT}, "identity");
    u_evr_host_model.xfer(12'h044, 1'b0, 8'h00, r, e);
    chk("unmapped_err", e, 1'b1);
    for (int p = 0; p < 2; p++) for (int b = 0; b < 8; b++) if (b != 6 && !(p == 1 && b == 7)) begin
      src(p, b, 1'b1);
      wr(p ? 12'h038 : 12'h034, ~(8'h01 << b));
      tick(12);
      chk("pin_gated", p ? pin_b : pin_a, 1'b0);
      wr(p ? 12'h038 : 12'h034, 8'h01 << b);
      tick(12);
      chk("pin_routed", p ? pin_b : pin_a, 1'b1);
      src(p, b, 1'b0);
      tick(12);
      chk("pin_idle", p ? pin_b : pin_a, 1'b0);
    end
    wr(12'h034, 8'h00);
    wr(12'h038, 8'h00);
    ffr <= 1'b1;
    tick(4);
    chk("pin_a_extra", pin_a, 1'b1);
    ffr <= 1'b0;
    sfr <= 1'b1;
    tick(4);
    chk("pin_b_extra", pin_b, 1'b1);
    sfr <= 1'b0;
    wr(12'h048, 8'h20);
    tick(4);
    chk("pin_low_idle", {pin_a, pin_b}, 2'h3);
    ffr <= 1'b1;
    tick(4);
    chk("pin_low_act", pin_a, 1'b0);
    ffr <= 1'b0;
    wr(12'h048, 8'h00);
    wr(12'h034, 8'h40);
    wr(12'h038, 8'h40);
    wr(12'h02c, 8'h01);
    wr(12'h030, 8'h03);
    batch(0, 258);
    tick(4);
    chk("below_thr", pin_a, 1'b0);
    batch(0, 1);
    tick(4);
    chk("hit_pins", {pin_a, pin_b}, 2'h3);
    rdc(12'h0ec, 32'h10, "status_hit");
    tick(4);
    chk("hit_cleared", pin_a, 1'b0);
    rdc(12'h0ec, 32'h0, "status_clr");
    wr(12'h02c, 8'h20);
    wr(12'h030, 8'h02);
    rdc(12'h030, 32'h02, "thr_low");
    batch(0, 3);
    batch(1, 1);
    wr(12'h02c, 8'h60);
    rdc(12'h02c, 32'h20, "clear_bit");
    batch(1, 1);
    rdc(12'h0ec, 32'h0, "after_clear");
    batch(1, 1);
    rdc(12'h0ec, 32'h10, "gyro_hit");
    wr(12'h034, 8'h00);
    wr(12'h038, 8'h00);
    for (int i = 0; i < 16; i++) begin
      wr(12'h040, {i[3:0], i[1:0], i[0], 1'b1});
      tick(2);
      chk("rate", {forbid, pdown, rate}, {i > 10, i == 0, i[3:0]});
      chk("range", rg, rtab[i[1:0]]);
      chk("filter", dat, i[0] ? 16'hbeef : 16'h1234);
      rdc(12'h040, {24'h0, i[3:0], i[1:0], i[0], 1'b0}, "accel_ctrl");
    end
    wr(12'h034, 8'h01);
    wr(12'h02c, 8'h80);
    src(0, 0, 1'b1);
    tick(3);
    chk("pulse_on", pin_a, 1'b1);
    tick(PULSE + 4);
    chk("pulse_off", pin_a, 1'b0);
    wrap_up();
  end
endmodule // evr_event_router_tb
bind evr_event_router evr_event_router_asserts #(.IDENTITY(IDENTITY)) u_evr_event_router_asserts (.*);

// ---- evr_host_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Host model: APB master on the register side.
// ----------------------------------------------------------------------------
module evr_host_model (
  // Clock.
  input  wire logic        clk_in,
  // APB master.
  output logic             psel_out,
  output logic             penable_out,
  output logic             pwrite_out,
  output logic      [11:0] paddr_out,
  output logic      [31:0] pwdata_out,
  input  wire logic [31:0] prdata_in,
  input  wire logic        pready_in,
  input  wire logic        pslverr_in
);
  // Idle bus from time zero.
  initial {psel_out, penable_out, pwrite_out, paddr_out, pwdata_out} = '0;
  // One transfer; stale address and data are inverted afterwards.
  task automatic xfer(input logic [11:0] a, input logic w, input logic [7:0] d, output logic [31:0] r,
                      output logic e);
    @(posedge clk_in);
    psel_out <= 1'b1;
    pwrite_out <= w;
    paddr_out <= a;
    pwdata_out <= {24'h0, d};
    @(posedge clk_in);
    penable_out <= 1'b1;
    do @(posedge clk_in); while (pready_in !== 1'b1);
    r = prdata_in;
    e = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    paddr_out <= ~a;
    pwdata_out <= ~{24'h0, d};
  endtask
  // Writes keep the two reserved bits at zero.
  task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic e);
    logic [31:0] r;
    logic [7:0]  v;
    v = d;
    if (a == 12'h038) v[7] = 1'b0;
    if (a == 12'h040) v[0] = 1'b0;
    xfer(a, 1'b1, v, r, e);
  endtask
endmodule // evr_host_model

// ---- evr_pkg.sv ----
// ----------------------------------------------------------------------------
// Shared constants for the event routing and accelerometer configuration block.
// ----------------------------------------------------------------------------
package evr_pkg;

  // --------------------------------------------------------------------------
  // Register indices; the APB byte address is four times the index.
  // --------------------------------------------------------------------------
  localparam logic [7:0] IDX_COUNT_CONTROL   = 8'h0b;
  localparam logic [7:0] IDX_THRESHOLD_LOW   = 8'h0c;
  localparam logic [7:0] IDX_PIN_A_ENABLE    = 8'h0d;
  localparam logic [7:0] IDX_PIN_B_ENABLE    = 8'h0e;
  localparam logic [7:0] IDX_IDENTITY        = 8'h0f;
  localparam logic [7:0] IDX_ACCEL_CONTROL   = 8'h10;
  localparam logic [7:0] IDX_PIN_CONTROL     = 8'h12;
  localparam logic [7:0] IDX_QUEUE_STATUS    = 8'h3b;

  // --------------------------------------------------------------------------
  // Field positions.
  // --------------------------------------------------------------------------
  localparam int CC_PULSED    = 7;
  localparam int CC_CLEAR     = 6;
  localparam int CC_SOURCE    = 5;
  localparam int EN_STAMP     = 7;
  localparam int EN_COUNT     = 6;
  localparam int EN_FULL      = 5;
  localparam int EN_OVERRUN   = 4;
  localparam int EN_LEVEL     = 3;
  localparam int EN_BOOT_TEMP = 2;
  localparam int EN_GYRO      = 1;
  localparam int EN_ACCEL     = 0;
  localparam int AC_FILTER2   = 1;
  localparam int PC_POLARITY  = 5;
  localparam int QS_COUNT_HIT = 4;

  // --------------------------------------------------------------------------
  // Reset values.
  // --------------------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;

  // --------------------------------------------------------------------------
  // Accelerometer rate codes.
  // --------------------------------------------------------------------------
  localparam logic [3:0] RATE_POWER_DOWN = 4'h0;
  localparam logic [3:0] RATE_HIGHEST    = 4'ha;

  // --------------------------------------------------------------------------
  // Timing: data-ready pulse length.
  // --------------------------------------------------------------------------
  localparam int PULSE_TIME_NS = 75000;
  localparam int CLK_RATE_MHZ  = 250;
  localparam int PULSE_CYCLES  = PULSE_TIME_NS * CLK_RATE_MHZ / 1000;

endpackage

// ---- evr_ready_shaper.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Data-ready shaper: latched until read, or a fixed-length pulse.
// ----------------------------------------------------------------------------
module evr_ready_shaper #(
  parameter int PULSE_CYCLES = evr_pkg::PULSE_CYCLES
) (
  // Clock and reset.
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Sample and read events.
  input  wire logic sample_in,
  input  wire logic read_in,
  input  wire logic pulsed_mode_in,
  // Shaped ready.
  output logic      ready_out
);

  localparam int CW = $clog2(PULSE_CYCLES + 1);

  typedef struct packed {
    logic          ready;
    logic [CW-1:0] left;
  } evr_rdy_state_t;

  evr_rdy_state_t state_reg;
  evr_rdy_state_t state_next;

  // A new sample wins over a read in the same cycle so no sample is lost.
  always_comb begin
    state_next = state_reg;
    if (pulsed_mode_in) begin
      if (sample_in) begin
        state_next.ready = 1'b1;
        state_next.left = CW'(PULSE_CYCLES - 1);
      end else if (state_reg.left != '0) begin
        state_next.left = state_reg.left - CW'(1);
      end else begin
        state_next.ready = 1'b0;
      end
    end else begin
      state_next.left = '0;
      if (sample_in) begin
        state_next.ready = 1'b1;
      end else if (read_in) begin
        state_next.ready = 1'b0;
      end
    end
  end

  // State register.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign ready_out = state_reg.ready;

endmodule // evr_ready_shaper
